// ===== hw/cse_defs.vh
`ifndef CSE_DEFS_VH
`define CSE_DEFS_VH
`define CSE_ADR_CTRL 4'h0
`define CSE_ADR_STAT 4'h1
`define CSE_ADR_IRQ 4'h2
`define CSE_ADR_MASK 4'h3
`define CSE_ADR_TEMP 4'h4
`define CSE_ADR_CUR 4'h5
`define CSE_CTRL_VARIANT 0
`define CSE_CTRL_TIMER_EN 1
`define CSE_CTRL_RESET 8'h00
`define CSE_EV_STATE 0
`define CSE_EV_FAULT 1
`define CSE_EV_DIE_SHUTDOWN_TEMP 2
`define CSE_EV_HOTCOLD 3
`define CSE_EV_W 4
`define CSE_HYST_C 8'd15
`define CSE_FLOOR_PCT 8'd25
`define CSE_FOLD_STEP 8'd5
`define CSE_FULL_PCT 8'd100
`define CSE_CLK_HZ 50000000
`define CSE_PQ_TIME_MS 1800000
`define CSE_FC_TIME_MS 10800000
`define CSE_MS_CYC (`CSE_CLK_HZ / 1000)
`endif

// ===== hw/cse_sync.v
`timescale 1ns/1ps
`default_nettype none
module cse_sync #(
    parameter W = 1
) (
    input wire clk_i, // clock
    input wire ce_i, // clock enable
    input wire [W-1:0] d_i, // async input
    output reg [W-1:0] q_o // synchronised
);
    reg [W-1:0] meta_reg;
    always @(posedge clk_i)
    begin
        if (ce_i)
        begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== hw/cse_top.v
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cse_defs.vh"
module cse_top #(
    parameter PQ_MS = `CSE_PQ_TIME_MS,
    parameter FC_MS = `CSE_FC_TIME_MS,
    parameter MS_CYC = `CSE_MS_CYC
) (
    input wire clk_i, // 50 MHz clock
    input wire rst_i, // synchronous reset, active high
    input wire ce_i, // clock enable
    input wire [3:0] wb_adr_i, // word address
    input wire [31:0] wb_dat_i, // write data
    output reg [31:0] wb_dat_o, // read data
    input wire [3:0] wb_sel_i, // byte lanes
    input wire wb_we_i, // write
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    output reg wb_ack_o, // ack
    output reg irq_o, // level interrupt
    input wire charge_disable_in_i, // charge disable pin
    input wire vin_above_2v_i, // comparator: input above about 2V
    input wire vin_uvlo_i, // comparator: input below undervoltage threshold
    input wire vin_ovlo_i, // comparator: input above overvoltage threshold
    input wire vin_headroom_i, // comparator: input above battery plus headroom
    input wire therm_cold_i, // thermistor below cold limit
    input wire therm_hot_i, // thermistor above hot limit
    input wire [7:0] die_temp_i, // die temperature, degrees
    input wire bat_low_i, // battery below prequal threshold
    input wire bat_dead_i, // battery in dead region
    input wire done_i, // done current reached
    input wire prog_short_i, // program pin shorted
    output reg status_line_a_oe_o, // pull line a low
    output reg status_line_b_oe_o, // pull line b low
    output reg status_line_c_oe_o, // pull line c low
    output reg gate_drive_regulator_en_o, // regulator enable
    output reg charger_on_o, // switching charger enable
    output reg [7:0] current_pct_o // charge current target percent
);
    localparam S_OFF = 7'b0000001;
    localparam S_DEAD = 7'b0000010;
    localparam S_PQ = 7'b0000100;
    localparam S_FC = 7'b0001000;
    localparam S_DONE = 7'b0010000;
    localparam S_FAULT = 7'b0100000;
    localparam S_SUSP = 7'b1000000;

    wire [10:0] pin_raw = {charge_disable_in_i, vin_above_2v_i, vin_uvlo_i, vin_ovlo_i,
        vin_headroom_i, therm_cold_i, therm_hot_i, bat_low_i, bat_dead_i, done_i,
        prog_short_i};
    wire [10:0] pin_s;
    wire [7:0] temp_s;
    cse_sync #(.W(11)) u_sync_pin (.clk_i(clk_i), .ce_i(ce_i), .d_i(pin_raw), .q_o(pin_s));
    cse_sync #(.W(8)) u_sync_temp (.clk_i(clk_i), .ce_i(ce_i), .d_i(die_temp_i),
        .q_o(temp_s));
    wire dis = pin_s[10];
    wire v2 = pin_s[9];
    wire uv = pin_s[8];
    wire ov = pin_s[7];
    wire hr = pin_s[6];
    wire cold = pin_s[5];
    wire hot = pin_s[4];
    wire blow = pin_s[3];
    wire bdead = pin_s[2];
    wire bdone = pin_s[1];
    wire pshort = pin_s[0];

    reg [7:0] ctrl_reg;
    reg [7:0] shdn_temp_reg;
    reg [7:0] reg_temp_reg;
    reg [`CSE_EV_W-1:0] irq_reg;
    reg [`CSE_EV_W-1:0] mask_reg;
    reg [6:0] state_reg;
    reg [6:0] state_next;
    reg [6:0] prior_reg;
    reg die_shutdown_temp_reg;
    reg dis_prev_reg;
    reg [31:0] ms_cnt_reg;
    reg [31:0] tmr_reg;
    reg [7:0] cur_next;
    reg [2:0] code3;
    reg [1:0] code2;

    wire variant3 = ctrl_reg[`CSE_CTRL_VARIANT];
    wire blocked = dis | uv | ~hr | die_shutdown_temp_reg | ~v2;
    wire charging = (state_reg == S_DEAD) | (state_reg == S_PQ) | (state_reg == S_FC);
    wire limit_hit = ctrl_reg[`CSE_CTRL_TIMER_EN] &&
        (((state_reg == S_FC) && (tmr_reg >= FC_MS)) ||
         ((state_reg != S_FC) && (tmr_reg >= PQ_MS)));

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_OFF:
            begin
                if (!blocked)
                    state_next = bdead ? S_DEAD : (blow ? S_PQ : S_FC);
            end
            S_DEAD, S_PQ, S_FC:
            begin
                if (pshort || limit_hit)
                    state_next = S_FAULT;
                else if (cold || hot || ov)
                    state_next = S_SUSP;
                else if (state_reg == S_DEAD && !bdead)
                    state_next = S_PQ;
                else if (state_reg == S_PQ && !blow)
                    state_next = S_FC;
                else if (state_reg == S_FC && bdone)
                    state_next = S_DONE;
            end
            S_SUSP:
            begin
                if (!cold && !hot && !ov)
                    state_next = prior_reg;
            end
            S_DONE:
            begin
                if (blow)
                    state_next = S_FC;
            end
            S_FAULT:
            begin
                state_next = S_FAULT;
            end
            default:
            begin
                state_next = S_OFF;
            end
        endcase
        if (blocked && state_reg != S_FAULT)
            state_next = S_OFF;
        if (state_reg == S_FAULT && ((dis_prev_reg && !dis) || !v2))
            state_next = S_OFF;
    end

    always @*
    begin
        cur_next = `CSE_FULL_PCT;
        if (temp_s > reg_temp_reg)
        begin
            if ((temp_s - reg_temp_reg) >= 8'd15)
                cur_next = `CSE_FLOOR_PCT;
            else
                cur_next = `CSE_FULL_PCT - `CSE_FOLD_STEP * (temp_s - reg_temp_reg);
            if (cur_next < `CSE_FLOOR_PCT)
                cur_next = `CSE_FLOOR_PCT;
        end
    end

    // line codes decoded from the registered state and pins
    always @*
    begin
        code3 = 3'b111;
        code2 = 2'b11;
        if (state_reg == S_FAULT)
        begin
            code3 = 3'b110;
            code2 = 2'b10;
        end
        else if (blocked)
        begin
            code3 = 3'b111;
            code2 = 2'b11;
        end
        else if (ov)
        begin
            code3 = 3'b001;
            code2 = 2'b10;
        end
        else if (cold)
        begin
            code3 = 3'b000;
            code2 = 2'b10;
        end
        else if (hot)
        begin
            code3 = 3'b011;
            code2 = 2'b10;
        end
        else if (charging)
        begin
            code3 = 3'b010;
            code2 = 2'b01;
        end
        else if (state_reg == S_DONE)
        begin
            code3 = 3'b100;
            code2 = 2'b11;
        end
    end

    wire [`CSE_EV_W-1:0] ev;
    assign ev[`CSE_EV_STATE] = state_next != state_reg;
    assign ev[`CSE_EV_FAULT] = state_next == S_FAULT && state_reg != S_FAULT;
    assign ev[`CSE_EV_DIE_SHUTDOWN_TEMP] = !die_shutdown_temp_reg && temp_s > shdn_temp_reg;
    assign ev[`CSE_EV_HOTCOLD] = state_next == S_SUSP && state_reg != S_SUSP;
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= S_OFF;
            prior_reg <= S_FC;
            die_shutdown_temp_reg <= 1'b0;
            dis_prev_reg <= 1'b0;
            ms_cnt_reg <= 32'h0;
            tmr_reg <= 32'h0;
            ctrl_reg <= `CSE_CTRL_RESET;
            shdn_temp_reg <= 8'h8c;
            reg_temp_reg <= 8'h73;
            irq_reg <= {`CSE_EV_W{1'b0}};
            mask_reg <= {`CSE_EV_W{1'b0}};
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            irq_o <= 1'b0;
            status_line_a_oe_o <= 1'b0;
            status_line_b_oe_o <= 1'b0;
            status_line_c_oe_o <= 1'b0;
            gate_drive_regulator_en_o <= 1'b0;
            charger_on_o <= 1'b0;
            current_pct_o <= `CSE_FULL_PCT;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
            dis_prev_reg <= dis;
            if (charging && state_next == S_SUSP)
                prior_reg <= state_reg;
            if (temp_s > shdn_temp_reg)
                die_shutdown_temp_reg <= 1'b1;
            else if ({1'b0, temp_s} + {1'b0, `CSE_HYST_C} <= {1'b0, shdn_temp_reg})
                die_shutdown_temp_reg <= 1'b0;
            // timers hold while suspended, restart on stage change
            if (state_next != state_reg && state_next != S_SUSP && state_reg != S_SUSP)
            begin
                tmr_reg <= 32'h0;
                ms_cnt_reg <= 32'h0;
            end
            else if (charging)
            begin
                if (ms_cnt_reg >= MS_CYC - 1)
                begin
                    ms_cnt_reg <= 32'h0;
                    tmr_reg <= tmr_reg + 32'h1;
                end
                else
                    ms_cnt_reg <= ms_cnt_reg + 32'h1;
            end
            status_line_a_oe_o <= variant3 ? ~code3[2] : ~code2[1];
            status_line_b_oe_o <= variant3 ? ~code3[1] : ~code2[0];
            status_line_c_oe_o <= variant3 ? ~code3[0] : hot;
            gate_drive_regulator_en_o <= ~dis & v2 & hr;
            charger_on_o <= charging & ~blocked & ~cold & ~hot & ~ov;
            current_pct_o <= cur_next;
            irq_reg <= (irq_reg & ~(bus_wr && wb_adr_i == `CSE_ADR_IRQ ?
                wb_dat_i[`CSE_EV_W-1:0] : {`CSE_EV_W{1'b0}})) | ev;
            irq_o <= |(irq_reg & mask_reg);
            wb_ack_o <= bus_req;
            if (bus_wr)
            begin
                case (wb_adr_i)
                    `CSE_ADR_CTRL: ctrl_reg <= wb_dat_i[7:0];
                    `CSE_ADR_MASK: mask_reg <= wb_dat_i[`CSE_EV_W-1:0];
                    `CSE_ADR_TEMP:
                    begin
                        if (wb_sel_i[1])
                            shdn_temp_reg <= wb_dat_i[15:8];
                        reg_temp_reg <= wb_dat_i[7:0];
                    end
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
            if (bus_req)
            begin
                case (wb_adr_i)
                    `CSE_ADR_CTRL: wb_dat_o <= {24'h0, ctrl_reg};
                    `CSE_ADR_STAT: wb_dat_o <= {16'h0, 7'h0, die_shutdown_temp_reg, 1'b0, state_reg};
                    `CSE_ADR_IRQ: wb_dat_o <= {28'h0, irq_reg};
                    `CSE_ADR_MASK: wb_dat_o <= {28'h0, mask_reg};
                    `CSE_ADR_TEMP: wb_dat_o <= {16'h0, shdn_temp_reg, reg_temp_reg};
                    `CSE_ADR_CUR: wb_dat_o <= {24'h0, current_pct_o};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/cse_props.sv
`timescale 1ns/1ps
`default_nettype none
module cse_props (
    input wire clk_i, // clock
    input wire rst_i, // reset
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_ack_o, // ack
    input wire charge_disable_in_i, // disable
    input wire vin_above_2v_i, // above 2v
    input wire vin_headroom_i, // headroom
    input wire therm_cold_i, // cold
    input wire therm_hot_i, // hot
    input wire [7:0] die_temp_i, // die temp
    input wire status_line_a_oe_o, // line a
    input wire status_line_b_oe_o, // line b
    input wire status_line_c_oe_o, // line c
    input wire gate_drive_regulator_en_o, // regulator
    input wire charger_on_o, // charger
    input wire [7:0] current_pct_o // current
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    rst_vals_a:
    assert property ($past(rst_i) |-> !(status_line_a_oe_o | status_line_b_oe_o
        | status_line_c_oe_o | gate_drive_regulator_en_o) && current_pct_o == 8'h64)
        else $error("outputs not at reset values");
    ack_next_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    reg_dis_a:
    assert property (charge_disable_in_i [*6] |-> !gate_drive_regulator_en_o)
        else $error("regulator on while disabled");
    reg_vin_a:
    assert property (!vin_above_2v_i [*6] |-> !gate_drive_regulator_en_o)
        else $error("regulator on with low input");
    reg_room_a:
    assert property (!vin_headroom_i [*6] |-> !gate_drive_regulator_en_o)
        else $error("regulator on without headroom");
    shdn_off_a:
    assert property ((die_temp_i > 8'h8c) [*6] |-> !charger_on_o) else $error("charger on hot die");
    hot_off_a:
    assert property (therm_hot_i [*6] |-> !charger_on_o) else $error("charger on hot battery");
    cold_off_a:
    assert property (therm_cold_i [*6] |-> !charger_on_o) else $error("charger on cold battery");
    cur_range_a:
    assert property (current_pct_o >= 8'h19 && current_pct_o <= 8'h64) else $error("current range");
    cool_full_a:
    assert property ((die_temp_i < 8'h73) [*6] |-> current_pct_o == 8'h64)
        else $error("current folded on cool die");
    cover property (charger_on_o && gate_drive_regulator_en_o);
    cover property (current_pct_o == 8'h19);
    cover property ($fell(status_line_c_oe_o));
endmodule
bind cse_top cse_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .charge_disable_in_i(charge_disable_in_i),
    .vin_above_2v_i(vin_above_2v_i), .vin_headroom_i(vin_headroom_i),
    .therm_cold_i(therm_cold_i), .therm_hot_i(therm_hot_i), .die_temp_i(die_temp_i),
    .status_line_a_oe_o(status_line_a_oe_o), .status_line_b_oe_o(status_line_b_oe_o),
    .status_line_c_oe_o(status_line_c_oe_o), .charger_on_o(charger_on_o),
    .gate_drive_regulator_en_o(gate_drive_regulator_en_o), .current_pct_o(current_pct_o));
`default_nettype wire

// ===== dv/cse_host.sv
`timescale 1ns/1ps
`default_nettype none
module cse_host (
    input wire clk_i, // clock
    input wire a_oe_i, // line a pulled
    input wire b_oe_i, // line b pulled
    input wire c_oe_i, // line c pulled
    output var logic [2:0] code_o // deglitched levels a,b,c
);
    logic [2:0] lines;
    logic [2:0] last_reg = 3'h7;
    logic [1:0] same_reg = 2'h0;
    // pull-ups: a released line reads high
    assign lines = {~a_oe_i, ~b_oe_i, ~c_oe_i};
    initial code_o = 3'h7;
    // lines may move apart, so a code is taken only after three quiet samples
    always @(posedge clk_i)
    begin
        last_reg <= lines;
        same_reg <= (lines != last_reg) ? 2'h0 : (same_reg == 2'h3) ? 2'h3 : same_reg + 2'h1;
        if (same_reg == 2'h3)
            code_o <= last_reg;
    end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i, rst_i, cyc, stb, we, look, dis, uvlo, ovlo, room, cold, hot, blow, bdead, done;
    logic pshort, vin_ok;
    logic [3:0] adr;
    logic [7:0] die;
    logic [31:0] wdat, rdat;
    logic [63:0] note;
    logic [63:0] exp_q[$];
    wire ack, irq, oa, ob, oc, rg, chg;
    wire [7:0] cur;
    wire [2:0] code;
    int err_total, n_compared, v, k;
    integer seed = 45;
    localparam logic [2:0] t3 [8] = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h7, 3'h7, 3'h7, 3'h7};
    localparam logic [2:0] t2 [8] = '{3'h3, 3'h5, 3'h5, 3'h4, 3'h7, 3'h7, 3'h7, 3'h7};
    cse_top #(.PQ_MS(5), .FC_MS(10), .MS_CYC(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(4'hf), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .irq_o(irq), .charge_disable_in_i(dis),
        .vin_above_2v_i(vin_ok), .vin_uvlo_i(uvlo), .vin_ovlo_i(ovlo), .vin_headroom_i(room),
        .therm_cold_i(cold), .therm_hot_i(hot), .die_temp_i(die), .bat_low_i(blow),
        .bat_dead_i(bdead), .done_i(done), .prog_short_i(pshort), .status_line_a_oe_o(oa),
        .status_line_b_oe_o(ob), .status_line_c_oe_o(oc), .gate_drive_regulator_en_o(rg),
        .charger_on_o(chg), .current_pct_o(cur));
    cse_host u_host (.clk_i(clk_i), .a_oe_i(oa), .b_oe_i(ob), .c_oe_i(oc), .code_o(code));
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [31:0] m);
        int n = 0;
        @(posedge clk_i);
        if (!w)
            exp_q.push_back({m, d & m});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20)
            err_total++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // e packs {current, irq, 2'b0, levels a b c, regulator, charger}
    task automatic pin(input logic [2:0] c, input logic [1:0] rc, input logic [7:0] p,
        input logic i, input logic [15:0] m);
        repeat (12) @(posedge clk_i);
        exp_q.push_back({16'h0, m, 16'h0, {p, i, 2'h0, c, rc} & m});
        look <= 1'b1;
        @(posedge clk_i);
        look <= 1'b0;
    endtask
    task automatic cond(input int j);
        dis <= (j == 4);
        uvlo <= (j == 5);
        ovlo <= (j == 2);
        room <= (j != 6);
        vin_ok <= (j != 6);
        cold <= (j == 1);
        hot <= (j == 3);
        die <= (j == 7) ? 8'h96 : 8'h19;
    endtask
    task automatic fault_exit();
        dis <= 1'b1;
        repeat (12) @(posedge clk_i);
        dis <= 1'b0;
        pin(v ? 3'h2 : 3'h3, 2'b11, 8'h0, 1'b0, 16'h009f);
    endtask
    always @(posedge clk_i)
    begin
        if ((ack === 1'b1 && we === 1'b0) || look === 1'b1)
        begin
            note = exp_q.pop_front();
            if (look === 1'b1)
                chk("pins", {16'h0, cur, irq, 2'h0, code, rg, chg} & note[63:32], note[31:0]);
            else
                chk("read", rdat & note[63:32], note[31:0]);
        end
    end
    initial
    begin
        #(20 * 20000);
        err_total++;
        summarize();
    end
    initial
    begin
        {cyc, stb, we, look, blow, done, pshort} = 7'h0;
        adr = 4'h0;
        wdat = 32'h0;
        bdead = 1'b1;
        cond(0);
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h0, 32'h0, 32'h3);
        wb(1'b0, 4'h4, 32'h8c73, 32'hffff);
        wb(1'b0, 4'h3, 32'h0, 32'hf);
        wb(1'b1, 4'hf, 32'hffffffff, 32'h0);
        wb(1'b0, 4'hf, 32'h0, 32'hffffffff);
        wb(1'b1, 4'h3, 32'h4, 32'h0);
        wb(1'b1, 4'h0, 32'h1, 32'h0);
        pin(3'h2, 2'b00, 8'h0, 1'b0, 16'h009c);
        bdead <= 1'b0;
        blow <= 1'b1;
        pin(3'h2, 2'b00, 8'h0, 1'b0, 16'h009c);
        blow <= 1'b0;
        for (v = 1; v >= 0; v--)
        begin
            wb(1'b1, 4'h0, v, 32'h0);
            for (k = 1; k < 8; k++)
            begin
                cond(k);
                pin(v ? t3[k] : t2[k], (k < 4) ? 2'b10 : 2'b00, 8'h0, k == 7,
                    (k == 5 || k == 7) ? 16'h009d : 16'h009f);
                if (k == 7)
                    wb(1'b0, 4'h1, 32'h100, 32'h100);
                cond(0);
                wb(1'b1, 4'h2, 32'hf, 32'h0);
                pin(v ? 3'h2 : 3'h3, 2'b11, 8'h0, 1'b0, 16'h009f);
            end
            done <= 1'b1;
            pin(v ? 3'h4 : 3'h7, 2'b00, 8'h0, 1'b0, 16'h009c);
            done <= 1'b0;
            fault_exit();
            wb(1'b1, 4'h0, v + 2, 32'h0);
            repeat (40) @(posedge clk_i);
            pin(v ? 3'h6 : 3'h5, 2'b00, 8'h0, 1'b0, 16'h009d);
            wb(1'b1, 4'h0, v, 32'h0);
            pin(v ? 3'h6 : 3'h5, 2'b00, 8'h0, 1'b0, 16'h009d);
            fault_exit();
            pshort <= 1'b1;
            pin(v ? 3'h6 : 3'h5, 2'b00, 8'h0, 1'b0, 16'h009d);
            pshort <= 1'b0;
            fault_exit();
            $display("status variant %0d finished", v);
        end
        die <= 8'h75;
        pin(3'h3, 2'b11, 8'h5a, 1'b0, 16'hff00);
        die <= 8'h8b;
        pin(3'h3, 2'b11, 8'h19, 1'b0, 16'hff00);
        die <= 8'h8c;
        pin(3'h3, 2'b11, 8'h19, 1'b0, 16'hff00);
        wb(1'b0, 4'h5, 32'h19, 32'hff);
        repeat (4)
        begin
            die <= 8'($unsigned($random(seed)) % 115);
            pin(3'h3, 2'b11, 8'h64, 1'b0, 16'hff00);
        end
        $display("foldback finished");
        summarize();
    end
endmodule
`default_nettype wire
